// ===== design/cpr_pkg.sv
package cpr_pkg;

  // ----------------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CHARGE_PATH = 8'h01;
  localparam logic [7:0] ADDR_PHASE_TIMERS = 8'h02;
  localparam logic [7:0] ADDR_PRECHARGE = 8'h03;
  localparam logic [7:0] ADDR_AUTO_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_CURRENT = 8'h05;
  localparam logic [7:0] ADDR_RESUME = 8'h06;
  localparam logic [7:0] ADDR_FLOAT = 8'h07;
  localparam logic [7:0] ADDR_TEMP_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_THERMISTOR = 8'h09;
  localparam logic [7:0] ADDR_REDUCTION = 8'h0a;
  localparam logic [7:0] ADDR_STATE_REPORT = 8'h0b;

  // ----------------------------------------------------------------------
  // Writable bit masks; reserved bits are zero here.
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_CHARGE_PATH = 8'h07;
  localparam logic [7:0] MASK_PHASE_TIMERS = 8'h3f;
  localparam logic [7:0] MASK_PRECHARGE = 8'h07;
  localparam logic [7:0] MASK_AUTO_TIMEOUT = 8'h01;
  localparam logic [7:0] MASK_CURRENT = 8'hdf;
  localparam logic [7:0] MASK_RESUME = 8'h0c;
  localparam logic [7:0] MASK_FLOAT = 8'h3f;
  localparam logic [7:0] MASK_TEMP_WINDOW = 8'h1f;
  localparam logic [7:0] MASK_THERMISTOR = 8'h07;
  localparam logic [7:0] MASK_REDUCTION = 8'h1f;
  localparam logic [7:0] MASK_STATE_REPORT = 8'h3f;

  // ----------------------------------------------------------------------
  // Reset values, one per register except the read-only state report.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CHARGE_PATH = 8'h06;
  localparam logic [7:0] RST_PHASE_TIMERS = 8'h36;
  localparam logic [7:0] RST_PRECHARGE = 8'h04;
  localparam logic [7:0] RST_AUTO_TIMEOUT = 8'h01;
  localparam logic [7:0] RST_CURRENT = 8'hc5;
  localparam logic [7:0] RST_RESUME = 8'h04;
  localparam logic [7:0] RST_FLOAT = 8'h1c;
  localparam logic [7:0] RST_TEMP_WINDOW = 8'h08;
  localparam logic [7:0] RST_THERMISTOR = 8'h02;
  localparam logic [7:0] RST_REDUCTION = 8'h16;

  // ----------------------------------------------------------------------
  // Field limits and field codes.
  // ----------------------------------------------------------------------
  localparam logic [5:0] FLOAT_CODE_MAX = 6'h28;
  localparam logic [2:0] HOT_CODE_MAX = 3'h4;
  localparam logic [1:0] NO_THERMISTOR = 2'h3;
  localparam logic [1:0] REDUCE_USE_CC = 2'h3;
  localparam logic [3:0] INT_CC_SAT_CODE = 4'hb;
  localparam logic [3:0] CC_FLOOR_CODE = 4'h1;

  // ----------------------------------------------------------------------
  // Timing constants.
  // ----------------------------------------------------------------------
  localparam int CLOCK_HZ = 40_000_000;
  // One minute of clock cycles at CLOCK_HZ, held unsigned because it exceeds the int range.
  localparam logic [31:0] MINUTE_CYCLES = 32'h8f0d_1800;
  localparam int GUARD_MINUTES = 20;

  // Phase timer limits in minutes; phase code zero means off, precharge code zero gives 360.
  localparam logic [8:0] PHASE_MIN_1 = 9'h005;
  localparam logic [8:0] PHASE_MIN_2 = 9'h00a;
  localparam logic [8:0] PHASE_MIN_3 = 9'h01e;
  localparam logic [8:0] PHASE_MIN_4 = 9'h03c;
  localparam logic [8:0] PHASE_MIN_5 = 9'h078;
  localparam logic [8:0] PHASE_MIN_6 = 9'h0f0;
  localparam logic [8:0] PHASE_MIN_7 = 9'h168;
  localparam logic [8:0] PRE_MIN_1 = 9'h001;

  // Charging phases reported by the charging core.
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_PRECHARGE,
    PH_CONST_CURRENT,
    PH_CONST_VOLTAGE,
    PH_DONE
  } cpr_phase_type;

  // Decoded settings handed to the analog loops.
  typedef struct packed {
    logic charge_allow;
    logic single_path;
    logic aux_input_boost_en;
    logic [1:0] end_of_charge_current;
    logic [3:0] cc_index;
    logic [1:0] restart_voltage_code;
    logic [5:0] float_voltage_code;
    logic [1:0] cold_limit;
    logic [2:0] hot_limit;
    logic [1:0] thermistor_select;
    logic thermistor_present;
    logic max_output_on_cv;
    logic small_sys_drop;
    logic [1:0] reduced_current_code;
    logic reduction_disable;
  } cpr_settings_type;

  // Events that return groups of registers to default.
  typedef struct packed {
    logic sw_watchdog;
    logic battery_gone;
    logic low_power;
  } cpr_reset_events_type;

endpackage

// ===== design/cpr_registers.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Charge allow bit gates all charging.
// - Auto restart below resume threshold when enabled.
// - Path bit picks parallel or single path.
// - Constant current and voltage phase timers.
// - Precharge timeout selects one to 360 minutes.
// - Twenty minute guard stops unserviced charging.
// - End of charge current code in bits 7:6.
// - Auxiliary input boost enable bit.
// - Constant current code, internal mode saturates.
// - Restart voltage code in bits 3:2.
// - Float voltage code capped at 4.5 V.
// - Cold limit code in bits 4:3.
// - Hot limit codes above four reserved.
// - Thermistor select, code three means none.
// - Maximum output current once voltage reached.
// - System rail drop selects 300 or 150 mV.
// - Load regulation interrupt when enabled.
// - Reduced current code and disable bit.
// - Each register group resets on listed events.
module cpr_registers
(
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rd_valid,
  input wire logic sw_watchdog_pin,
  input wire logic battery_gone_pin,
  input wire logic low_power_pin,
  input wire logic software_mode,
  input wire logic guard_service,
  input wire logic internal_mode,
  input wire logic [2:0] phase_in,
  input wire logic vbat_below_resume,
  input wire logic load_regulating,
  input wire logic [2:0] source_detect_state,
  input wire logic [2:0] charger_state,
  output cpr_pkg::cpr_settings_type settings,
  output logic charge_run,
  output logic restart_pulse,
  output logic phase_timeout,
  output logic load_irq
);

  // ----------------------------------------------------------------------
  // Reset event synchronisers.
  // ----------------------------------------------------------------------

  // Raw first stage, read only by the second stage.
  cpr_pkg::cpr_reset_events_type ev_meta_q;
  // Synchronised events.
  cpr_pkg::cpr_reset_events_type ev_q;

  // The events come from analog monitors outside this clock domain.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ev_meta_q <= '0;
      ev_q <= '0;
    end
    else
    begin
      ev_meta_q <= '{sw_watchdog_pin, battery_gone_pin, low_power_pin};
      ev_q <= ev_meta_q;
    end
  end

  // Group reset strobes, one per reset source combination.
  logic grp_wd_lp;
  logic grp_bat_lp;
  logic grp_all;
  logic grp_lp;
  assign grp_wd_lp = rst | ev_q.sw_watchdog | ev_q.low_power;
  assign grp_bat_lp = rst | ev_q.battery_gone | ev_q.low_power;
  assign grp_all = grp_wd_lp | ev_q.battery_gone;
  assign grp_lp = rst | ev_q.low_power;

  // Write strobe helper, one per offset.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a == off;
  endfunction

  // ----------------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------------

  // Register storage at full byte width; masks drop reserved bits.
  logic [7:0] path_q;
  logic [7:0] timers_q;
  logic [7:0] pre_q;
  logic [7:0] auto_q;
  logic [7:0] cur_q;
  logic [7:0] resume_q;
  logic [7:0] float_q;
  logic [7:0] temp_q;
  logic [7:0] therm_q;
  logic [7:0] reduce_q;

  // Watchdog and low power group.
  always_ff @(posedge clock)
  begin
    if (grp_wd_lp)
    begin
      path_q <= cpr_pkg::RST_CHARGE_PATH;
      auto_q <= cpr_pkg::RST_AUTO_TIMEOUT;
      therm_q <= cpr_pkg::RST_THERMISTOR;
    end
    else if (wr_en)
    begin
      if (hit(addr, cpr_pkg::ADDR_CHARGE_PATH))
      begin
        path_q <= wdata & cpr_pkg::MASK_CHARGE_PATH;
      end
      // Turning the guard off is honoured only under software control.
      if (hit(addr, cpr_pkg::ADDR_AUTO_TIMEOUT) && (software_mode || wdata[0]))
      begin
        auto_q <= wdata & cpr_pkg::MASK_AUTO_TIMEOUT;
      end
      if (hit(addr, cpr_pkg::ADDR_THERMISTOR))
      begin
        therm_q <= wdata & cpr_pkg::MASK_THERMISTOR;
      end
    end
  end

  // Battery disconnect and low power group.
  always_ff @(posedge clock)
  begin
    if (grp_bat_lp)
    begin
      timers_q <= cpr_pkg::RST_PHASE_TIMERS;
      pre_q <= cpr_pkg::RST_PRECHARGE;
      resume_q <= cpr_pkg::RST_RESUME;
      temp_q <= cpr_pkg::RST_TEMP_WINDOW;
    end
    else if (wr_en)
    begin
      if (hit(addr, cpr_pkg::ADDR_PHASE_TIMERS))
      begin
        timers_q <= wdata & cpr_pkg::MASK_PHASE_TIMERS;
      end
      if (hit(addr, cpr_pkg::ADDR_PRECHARGE))
      begin
        pre_q <= wdata & cpr_pkg::MASK_PRECHARGE;
      end
      if (hit(addr, cpr_pkg::ADDR_RESUME))
      begin
        resume_q <= wdata & cpr_pkg::MASK_RESUME;
      end
      // Reserved hot codes are refused so the window stays meaningful.
      if (hit(addr, cpr_pkg::ADDR_TEMP_WINDOW) && wdata[2:0] <= cpr_pkg::HOT_CODE_MAX)
      begin
        temp_q <= wdata & cpr_pkg::MASK_TEMP_WINDOW;
      end
    end
  end

  // Registers cleared by any of the three events.
  always_ff @(posedge clock)
  begin
    if (grp_all)
    begin
      cur_q <= cpr_pkg::RST_CURRENT;
      float_q <= cpr_pkg::RST_FLOAT;
    end
    else if (wr_en)
    begin
      if (hit(addr, cpr_pkg::ADDR_CURRENT))
      begin
        cur_q <= wdata & cpr_pkg::MASK_CURRENT;
      end
      // Codes past the top are clamped to 4.5 V.
      if (hit(addr, cpr_pkg::ADDR_FLOAT))
      begin
        if (wdata[5:0] > cpr_pkg::FLOAT_CODE_MAX)
        begin
          float_q <= {2'b00, cpr_pkg::FLOAT_CODE_MAX};
        end
        else
        begin
          float_q <= wdata & cpr_pkg::MASK_FLOAT;
        end
      end
    end
  end

  // Low power only group.
  always_ff @(posedge clock)
  begin
    if (grp_lp)
    begin
      reduce_q <= cpr_pkg::RST_REDUCTION;
    end
    else if (wr_en && hit(addr, cpr_pkg::ADDR_REDUCTION))
    begin
      reduce_q <= wdata & cpr_pkg::MASK_REDUCTION;
    end
  end

  // ----------------------------------------------------------------------
  // Settings decode.
  // ----------------------------------------------------------------------

  // Current index: internal mode saturates, code zero behaves as one.
  logic [3:0] cc_idx;
  always_comb
  begin
    cc_idx = cur_q[3:0];
    if (cc_idx < cpr_pkg::CC_FLOOR_CODE)
    begin
      cc_idx = cpr_pkg::CC_FLOOR_CODE;
    end
    if (internal_mode && cc_idx > cpr_pkg::INT_CC_SAT_CODE)
    begin
      cc_idx = cpr_pkg::INT_CC_SAT_CODE;
    end
  end

  // Settings are registered so every output leaves a flip-flop.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      settings <= '0;
    end
    else
    begin
      settings.charge_allow <= path_q[2];
      settings.single_path <= path_q[0];
      settings.aux_input_boost_en <= cur_q[4];
      settings.end_of_charge_current <= cur_q[7:6];
      settings.cc_index <= cc_idx;
      settings.restart_voltage_code <= resume_q[3:2];
      settings.float_voltage_code <= float_q[5:0];
      settings.cold_limit <= temp_q[4:3];
      settings.hot_limit <= temp_q[2:0];
      settings.thermistor_select <= therm_q[2:1];
      settings.thermistor_present <= therm_q[2:1] != cpr_pkg::NO_THERMISTOR;
      settings.max_output_on_cv <= therm_q[0];
      settings.small_sys_drop <= reduce_q[4];
      settings.reduced_current_code <= reduce_q[2:1];
      // Only the disable bit itself turns the reduction off; code three keeps the CC level.
      settings.reduction_disable <= reduce_q[0];
    end
  end

  // ----------------------------------------------------------------------
  // Phase timers and the twenty minute guard.
  // ----------------------------------------------------------------------

  // Limit in minutes for a phase timer code.
  function automatic logic [8:0] phase_limit(input logic [2:0] code);
    unique case (code)
      3'h1: phase_limit = cpr_pkg::PHASE_MIN_1;
      3'h2: phase_limit = cpr_pkg::PHASE_MIN_2;
      3'h3: phase_limit = cpr_pkg::PHASE_MIN_3;
      3'h4: phase_limit = cpr_pkg::PHASE_MIN_4;
      3'h5: phase_limit = cpr_pkg::PHASE_MIN_5;
      3'h6: phase_limit = cpr_pkg::PHASE_MIN_6;
      3'h7: phase_limit = cpr_pkg::PHASE_MIN_7;
      default: phase_limit = '0;
    endcase
  endfunction

  // Precharge scale is shifted one step down from the phase scale.
  function automatic logic [8:0] pre_limit(input logic [2:0] code);
    if (code == 3'h1)
    begin
      pre_limit = cpr_pkg::PRE_MIN_1;
    end
    else
    begin
      pre_limit = phase_limit(code - 3'h1);
    end
  endfunction

  // Minute tick from a divider.
  logic [31:0] tick_cnt_q;
  logic minute_tick;
  assign minute_tick = tick_cnt_q == (cpr_pkg::MINUTE_CYCLES - 32'h0000_0001);
  always_ff @(posedge clock)
  begin
    if (rst || minute_tick)
    begin
      tick_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // Phase minutes restart whenever the phase changes.
  logic [2:0] phase_prev_q;
  logic [8:0] phase_min_q;
  logic [8:0] active_limit;
  always_comb
  begin
    active_limit = '0;
    if (phase_in == 3'(cpr_pkg::PH_PRECHARGE)) active_limit = pre_limit(pre_q[2:0]);
    if (phase_in == 3'(cpr_pkg::PH_CONST_CURRENT)) active_limit = phase_limit(timers_q[5:3]);
    if (phase_in == 3'(cpr_pkg::PH_CONST_VOLTAGE)) active_limit = phase_limit(timers_q[2:0]);
  end

  // Sticky phase expiry, cleared by a new phase.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      phase_prev_q <= '0;
      phase_min_q <= '0;
      phase_timeout <= 1'b0;
    end
    else
    begin
      phase_prev_q <= phase_in;
      if (phase_in != phase_prev_q)
      begin
        phase_min_q <= '0;
        phase_timeout <= 1'b0;
      end
      else
      begin
        if (minute_tick && phase_min_q != 9'h1ff)
        begin
          phase_min_q <= phase_min_q + 9'h001;
        end
        if (active_limit != '0 && phase_min_q >= active_limit)
        begin
          phase_timeout <= 1'b1;
        end
      end
    end
  end

  // Guard counts minutes since the last service.
  logic [4:0] guard_min_q;
  logic guard_expired_q;
  always_ff @(posedge clock)
  begin
    if (rst || guard_service || !auto_q[0])
    begin
      guard_min_q <= '0;
      guard_expired_q <= 1'b0;
    end
    else if (minute_tick)
    begin
      if (guard_min_q == 5'(cpr_pkg::GUARD_MINUTES - 1))
      begin
        guard_expired_q <= 1'b1;
      end
      else
      begin
        guard_min_q <= guard_min_q + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Charge gating, restart and interrupt.
  // ----------------------------------------------------------------------

  // A restart needs auto restart, charge allowed and charging finished.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      charge_run <= 1'b0;
      restart_pulse <= 1'b0;
      load_irq <= 1'b0;
    end
    else
    begin
      charge_run <= path_q[2] & ~guard_expired_q & ~phase_timeout;
      restart_pulse <= path_q[1] & path_q[2] & ~software_mode & vbat_below_resume
        & (phase_in == 3'(cpr_pkg::PH_DONE));
      load_irq <= reduce_q[3] & load_regulating;
    end
  end

  // ----------------------------------------------------------------------
  // Read port; unmapped offsets return zero.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      unique case (addr)
        cpr_pkg::ADDR_CHARGE_PATH: rdata <= path_q;
        cpr_pkg::ADDR_PHASE_TIMERS: rdata <= timers_q;
        cpr_pkg::ADDR_PRECHARGE: rdata <= pre_q;
        cpr_pkg::ADDR_AUTO_TIMEOUT: rdata <= auto_q;
        cpr_pkg::ADDR_CURRENT: rdata <= cur_q;
        cpr_pkg::ADDR_RESUME: rdata <= resume_q;
        cpr_pkg::ADDR_FLOAT: rdata <= float_q;
        cpr_pkg::ADDR_TEMP_WINDOW: rdata <= temp_q;
        cpr_pkg::ADDR_THERMISTOR: rdata <= therm_q;
        cpr_pkg::ADDR_REDUCTION: rdata <= reduce_q;
        cpr_pkg::ADDR_STATE_REPORT: rdata <= {2'b00, source_detect_state, charger_state}
          & cpr_pkg::MASK_STATE_REPORT;
        default: rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  property p_allow_gate;
    @(posedge clock) disable iff (rst) !path_q[2] |=> !charge_run;
  endproperty
  a_allow_gate: assert property (p_allow_gate) else $error("charge ran while disallowed");

  property p_float_cap;
    @(posedge clock) disable iff (rst) float_q[5:0] <= cpr_pkg::FLOAT_CODE_MAX;
  endproperty
  a_float_cap: assert property (p_float_cap) else $error("float code above cap");

  property p_reserved_zero;
    @(posedge clock) disable iff (rst) path_q[7:3] == '0 && reduce_q[7:5] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_irq_mask;
    @(posedge clock) disable iff (rst) !reduce_q[3] |=> !load_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");

  property p_lp_reset;
    @(posedge clock) disable iff (rst) ev_q.low_power |=> reduce_q == cpr_pkg::RST_REDUCTION;
  endproperty
  a_lp_reset: assert property (p_lp_reset) else $error("low power did not reset");

  // Refused writes must never leave a reserved hot code behind.
  property p_hot_legal;
    @(posedge clock) disable iff (rst) temp_q[2:0] <= cpr_pkg::HOT_CODE_MAX;
  endproperty
  a_hot_legal: assert property (p_hot_legal) else $error("reserved hot code held");

  // Under software control the restart decision belongs to the host.
  property p_restart_sw;
    @(posedge clock) disable iff (rst) software_mode |=> !restart_pulse;
  endproperty
  a_restart_sw: assert property (p_restart_sw) else $error("restart under host control");

endmodule

// ===== verification/charger_parameter_registers_tb.sv
`timescale 1ns/1ps
module charger_parameter_registers_tb;
  // ----------------------------------------------------------------------
  // Bench signals; every design input starts at a known value.
  // ----------------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [2:0] ev_pins = 3'h0; // Watchdog, battery gone, low power.
  logic software_mode = 1'b0;
  logic guard_service = 1'b0;
  logic internal_mode = 1'b0;
  logic [2:0] phase_in = 3'h0;
  logic vbat_below_resume = 1'b0;
  logic load_regulating = 1'b0;
  logic [2:0] source_detect_state = 3'h0;
  logic [2:0] charger_state = 3'h0;
  logic [7:0] rdata;
  logic rd_valid;
  cpr_pkg::cpr_settings_type settings;
  logic charge_run;
  logic restart_pulse;
  logic phase_timeout;
  logic load_irq;
  logic [7:0] model [1:10]; // What each register should hold now.
  logic [7:0] d;
  logic seen;
  int failures = 0;
  int cmp_count = 0;
  int seed = 17;

  // Guard service toggles at random; a twenty minute expiry is far beyond this run.
  cpr_registers cpr_registers_inst (
    .clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rd_valid(rd_valid), .sw_watchdog_pin(ev_pins[0]),
    .battery_gone_pin(ev_pins[1]), .low_power_pin(ev_pins[2]),
    .software_mode(software_mode), .guard_service(guard_service), .internal_mode(internal_mode),
    .phase_in(phase_in), .vbat_below_resume(vbat_below_resume),
    .load_regulating(load_regulating), .source_detect_state(source_detect_state),
    .charger_state(charger_state), .settings(settings), .charge_run(charge_run),
    .restart_pulse(restart_pulse), .phase_timeout(phase_timeout), .load_irq(load_irq));

  // Clock of 25 ns period.
  always #12.5 clock = ~clock;

  // ----------------------------------------------------------------------
  // Expectation helpers.
  // ----------------------------------------------------------------------
  // Default value in the upper byte, writable bits in the lower byte.
  function automatic logic [15:0] reg_tbl(input logic [7:0] a);
    case (a)
      8'h01: return 16'h0607;
      8'h02: return 16'h363f;
      8'h03: return 16'h0407;
      8'h04: return 16'h0101;
      8'h05: return 16'hc5df;
      8'h06: return 16'h040c;
      8'h07: return 16'h1c3f;
      8'h08: return 16'h081f;
      8'h09: return 16'h0207;
      default: return 16'h161f;
    endcase
  endfunction

  // Value a register holds after a write; refused writes leave the old value.
  function automatic logic [7:0] wr_exp(input logic [7:0] a, old, dat, input logic swm);
    logic [15:0] t;
    logic [7:0] v;
    t = reg_tbl(a);
    v = dat & t[7:0];
    if (a == 8'h04 && !dat[0] && !swm) v = old;
    if (a == 8'h08 && dat[2:0] > 3'h4) v = old;
    if (a == 8'h07 && v[5:0] > 6'h28) v = 8'h28;
    return v;
  endfunction

  // True when event ev (0 watchdog, 1 battery gone, 2 low power) resets register a.
  function automatic logic hit(input logic [7:0] a, input int ev);
    case (ev)
      0: return a inside {8'h01, 8'h04, 8'h05, 8'h07, 8'h09};
      1: return a inside {8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08};
      default: return 1'b1;
    endcase
  endfunction

  // Decoded settings expected from the register contents.
  function automatic cpr_pkg::cpr_settings_type exp_set();
    cpr_pkg::cpr_settings_type s;
    logic [3:0] c;
    s.charge_allow = model[1][2];
    s.single_path = model[1][0];
    s.aux_input_boost_en = model[5][4];
    s.end_of_charge_current = model[5][7:6];
    c = model[5][3:0];
    if (c == 4'h0) c = 4'h1; // Codes 0 and 1 give the same current.
    if (internal_mode && c > 4'hb) c = 4'hb; // Internal mode saturates.
    s.cc_index = c;
    s.restart_voltage_code = model[6][3:2];
    s.float_voltage_code = model[7][5:0];
    s.cold_limit = model[8][4:3];
    s.hot_limit = model[8][2:0];
    s.thermistor_select = model[9][2:1];
    s.thermistor_present = (model[9][2:1] != 2'h3);
    s.max_output_on_cv = model[9][0];
    s.small_sys_drop = model[10][4];
    s.reduced_current_code = model[10][2:1];
    s.reduction_disable = model[10][0];
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // Bus tasks and checks; inputs change only at the falling edge.
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, dat);
    @(negedge clock);
    wr_en = 1'b1;
    addr = a;
    wdata = dat;
    @(negedge clock);
    wr_en = 1'b0;
  endtask

  // Read with a bounded wait for the answer strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    int n;
    @(negedge clock);
    rd_en = 1'b1;
    addr = a;
    @(negedge clock);
    rd_en = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 3)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 3)
    begin
      failures++;
      results();
    end
    dat = rdata;
  endtask

  // Write, read back, and compare register, settings and run gate.
  task automatic wr_chk(input logic [7:0] a, dat, input logic swm);
    software_mode = swm;
    internal_mode = 1'($random(seed));
    guard_service = 1'($random(seed));
    wr(a, dat);
    model[a] = wr_exp(a, model[a], dat, swm);
    rd(a, d);
    check(d, model[a]);
    check(32'(settings), 32'(exp_set()));
    check(charge_run, model[1][2]);
    check(phase_timeout, 1'b0);
  endtask

  // Six cycles of watching one output: 0 interrupt, 1 restart pulse.
  task automatic watch(input int w);
    seen = 1'b0;
    repeat (6)
    begin
      @(negedge clock);
      if ((w == 0 ? load_irq : restart_pulse) === 1'b1) seen = 1'b1;
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    // Defaults after reset, then the read-only report.
    for (int i = 1; i <= 10; i++)
    begin
      model[i] = 8'(reg_tbl(8'(i)) >> 8);
      rd(8'(i), d);
      check(d, model[i]);
    end
    source_detect_state = 3'($random(seed));
    charger_state = 3'($random(seed));
    wr(8'h0b, 8'hff);
    rd(8'h0b, d);
    check(d, {2'b00, source_detect_state, charger_state});
    $display("test defaults done");
    // Clamp, refusals and boundary codes first, then random traffic.
    wr_chk(8'h07, 8'hff, 1'b0);
    wr_chk(8'h08, 8'h1d, 1'b0);
    wr_chk(8'h04, 8'h00, 1'b0);
    wr_chk(8'h04, 8'h00, 1'b1);
    wr_chk(8'h05, 8'h3f, 1'b0);
    wr_chk(8'h01, 8'h00, 1'b0);
    repeat (60) wr_chk(8'(({$random(seed)} % 10) + 1), 8'($random(seed)), 1'b1);
    $display("test writes done");
    // Each reset event returns only its own group to defaults.
    for (int ev = 0; ev < 3; ev++)
    begin
      for (int i = 1; i <= 10; i++) wr_chk(8'(i), 8'($random(seed)), 1'b1);
      ev_pins[ev] = 1'b1;
      repeat (4) @(negedge clock);
      ev_pins = 3'h0;
      repeat (4) @(negedge clock);
      for (int i = 1; i <= 10; i++)
      begin
        if (hit(8'(i), ev)) model[i] = 8'(reg_tbl(8'(i)) >> 8);
        rd(8'(i), d);
        check(d, model[i]);
      end
    end
    $display("test reset events done");
    // Load regulation interrupt, masked then enabled.
    wr_chk(8'h0a, 8'h00, 1'b0);
    load_regulating = 1'b1;
    watch(0);
    check(seen, 1'b0);
    wr_chk(8'h0a, 8'h08, 1'b0);
    watch(0);
    check(seen, 1'b1);
    $display("test interrupt done");
    // Automatic restart after charge done, off then on.
    phase_in = 3'h4;
    wr_chk(8'h01, 8'h05, 1'b0);
    vbat_below_resume = 1'b1;
    watch(1);
    check(seen, 1'b0);
    vbat_below_resume = 1'b0;
    wr_chk(8'h01, 8'h07, 1'b0);
    vbat_below_resume = 1'b1;
    watch(1);
    check(seen, 1'b1);
    $display("test restart done");
    results();
  end

  // Cut a hang short.
  initial
  begin
    repeat (100000) @(posedge clock);
    failures++;
    results();
  end
endmodule
